// ==== rtl/irq_unit.sv ====
module irq_unit #(
    parameter int N = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // events and register writes
    input wire logic [N-1:0] ev,
    input wire logic wr_stat,
    input wire logic wr_mask,
    input wire logic [N-1:0] wdata,
    // state
    output logic [N-1:0] stat,
    output logic [N-1:0] mask,
    output logic irq
);

    typedef struct packed {
        logic [N-1:0] stat;
        logic [N-1:0] mask;
        logic irq;
    } irq_state_t;

    irq_state_t r, n;

    // =====================================================
    // write one clears, a new event wins
    always_comb begin
        n = r;
        if (wr_stat) begin
            n.stat = r.stat & ~wdata;
        end
        n.stat = n.stat | ev;
        if (wr_mask) begin
            n.mask = wdata;
        end
        n.irq = |(n.stat & n.mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign stat = r.stat;
    assign mask = r.mask;
    assign irq = r.irq;

endmodule

// ==== rtl/sie_pkg.sv ====
package sie_pkg;

    // =====================================================
    // register offsets
    localparam logic [7:0] OFS_DEV_ADDR = 8'h42;
    localparam logic [7:0] OFS_SIE_STATUS = 8'h45;
    localparam logic [7:0] OFS_FIFO_CMD = 8'h46;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h4C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h4D;

    // =====================================================
    // sie_status fields
    localparam int SIE_DEFER = 0;
    localparam int SIE_CTRL_FIFO_ERROR = 1;
    localparam int SIE_OUT = 2;
    localparam int SIE_IN = 3;
    localparam int SIE_NAK = 4;
    localparam int SIE_CRC = 5;
    localparam int SIE_END_OF_TRANSFER = 6;
    localparam int SIE_NAK_IRQ_MASK = 7;

    // =====================================================
    // fifo_command_status fields
    localparam int FC_REQ = 0;
    localparam int FC_TX = 1;
    localparam int FC_CLR = 2;
    localparam int FC_SEL_LO = 3;
    localparam int FC_SEL_HI = 4;
    localparam int FC_SETUP = 5;
    localparam int FC_READY = 6;
    localparam int FC_ZLEN = 7;

    // =====================================================
    // fifo select codes
    localparam logic [1:0] SEL_FIFO0 = 2'h0;
    localparam logic [1:0] SEL_FIFO1 = 2'h1;
    localparam logic [1:0] SEL_FIFO2 = 2'h2;

    // =====================================================
    // sticky flag indices, interrupt event indices
    localparam int FL_CTRL_FIFO_ERROR = 0;
    localparam int FL_OUT = 1;
    localparam int FL_CRC = 2;
    localparam int FL_SETUP = 3;
    localparam int FL_ZLEN = 4;
    localparam int NUM_FLAGS = 5;
    localparam int NUM_IRQ = 6;

    // =====================================================
    // reset values
    localparam logic [7:0] DEV_ADDR_RST = 8'h00;
    localparam logic [7:0] FIFO_CMD_RST = 8'h00;
    localparam logic NAK_IRQ_MASK_RST = 1'b0;

    typedef struct packed {
        logic token_start;
        logic token_is_in;
        logic in_done;
        logic nak_sent;
        logic crc_err;
        logic ctrl_fifo_error;
        logic out_rx;
        logic setup_rx;
        logic zero_len_rx;
        logic fifo_data_rd;
        logic end_of_transfer_ok;
        logic fifo_ready;
    } sie_ev_t;

    typedef struct packed {
        logic req;
        logic tx;
        logic clr;
        logic [1:0] sel;
    } fifo_cmd_t;

    typedef struct packed {
        logic q;
    } flag_state_t;

endpackage

// ==== rtl/sie_regs.sv ====
// Contract
// - deferred mode loads address after IN done
// - engine clears deferred bit after loading
// - immediate mode loads address on write
// - fifo0 access error sets bit 1
// - nonzero OUT token sets bit 2
// - next valid SETUP clears OUT flag
// - bit 3 shows current token is IN
// - bit 4 shows NAK was sent
// - CRC error sets bit 5
// - bit 6 shows end of transfer state
// - bit 7 masks NAK interrupt, resets 0
// - fifo command register bit layout
// - select 00/01/10 picks fifo 0/1/2
// - firmware raises then drops request bit
// - zero length flag set, cleared by read/SETUP
//
// Implementation choice: strobed register access.
module sie_regs (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] BUS_ADDR,
    input wire logic [7:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [7:0] BUS_RDATA,
    // engine side
    input wire sie_pkg::sie_ev_t SIE_EV,
    output logic [6:0] DEV_ADDR,
    output logic REMOTE_WAKEUP,
    output sie_pkg::fifo_cmd_t FIFO_CMD,
    // interrupt
    output logic IRQ
);

    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] addr_reg;
        logic [6:0] dev_addr;
        logic defer;
        logic in_tok;
        logic nak;
        logic end_of_transfer_ok;
        logic nak_irq_mask;
        sie_pkg::fifo_cmd_t cmd;
    } top_state_t;

    top_state_t r, n;

    logic wr_dev, wr_sie, wr_fc, wr_ist, wr_imk;
    logic [sie_pkg::NUM_FLAGS-1:0] fl_set, fl_clr, fl_q;
    logic [sie_pkg::NUM_IRQ-1:0] irq_ev, irq_stat, irq_mask;
    logic [7:0] sie_view, fc_view;

    // =====================================================
    // address decode
    assign wr_dev = BUS_WR && (BUS_ADDR == sie_pkg::OFS_DEV_ADDR);
    assign wr_sie = BUS_WR && (BUS_ADDR == sie_pkg::OFS_SIE_STATUS);
    assign wr_fc = BUS_WR && (BUS_ADDR == sie_pkg::OFS_FIFO_CMD);
    assign wr_ist = BUS_WR && (BUS_ADDR == sie_pkg::OFS_IRQ_STATUS);
    assign wr_imk = BUS_WR && (BUS_ADDR == sie_pkg::OFS_IRQ_MASK);

    // =====================================================
    // sticky flags
    always_comb begin
        fl_set = '0;
        fl_clr = '0;
        fl_set[sie_pkg::FL_CTRL_FIFO_ERROR] = SIE_EV.ctrl_fifo_error;
        fl_set[sie_pkg::FL_OUT] = SIE_EV.out_rx;
        fl_set[sie_pkg::FL_CRC] = SIE_EV.crc_err;
        fl_set[sie_pkg::FL_SETUP] = SIE_EV.setup_rx;
        fl_set[sie_pkg::FL_ZLEN] = SIE_EV.zero_len_rx;
        fl_clr[sie_pkg::FL_CTRL_FIFO_ERROR] = wr_sie && !BUS_WDATA[sie_pkg::SIE_CTRL_FIFO_ERROR];
        fl_clr[sie_pkg::FL_OUT] = (wr_sie && !BUS_WDATA[sie_pkg::SIE_OUT]) || SIE_EV.setup_rx;
        fl_clr[sie_pkg::FL_CRC] = wr_sie && !BUS_WDATA[sie_pkg::SIE_CRC];
        fl_clr[sie_pkg::FL_SETUP] = wr_fc && !BUS_WDATA[sie_pkg::FC_SETUP];
        fl_clr[sie_pkg::FL_ZLEN] = (wr_fc && !BUS_WDATA[sie_pkg::FC_ZLEN]) || SIE_EV.fifo_data_rd
            || SIE_EV.setup_rx;
    end

    genvar gi;
    generate
        for (gi = 0; gi < sie_pkg::NUM_FLAGS; gi++) begin : g_flag
            sticky_flag u_flag (
                .clk(MCLK),
                .rst(RST),
                .set(fl_set[gi]),
                .clr(fl_clr[gi]),
                .q(fl_q[gi])
            );
        end
    endgenerate

    // =====================================================
    // interrupt events
    assign irq_ev = {SIE_EV.zero_len_rx, SIE_EV.setup_rx, SIE_EV.nak_sent && !r.nak_irq_mask,
        SIE_EV.crc_err, SIE_EV.out_rx, SIE_EV.ctrl_fifo_error};

    irq_unit #(
        .N(sie_pkg::NUM_IRQ)
    ) u_irq (
        .clk(MCLK),
        .rst(RST),
        .ev(irq_ev),
        .wr_stat(wr_ist),
        .wr_mask(wr_imk),
        .wdata(BUS_WDATA[sie_pkg::NUM_IRQ-1:0]),
        .stat(irq_stat),
        .mask(irq_mask),
        .irq(IRQ)
    );

    // =====================================================
    // read views
    always_comb begin
        sie_view = 8'h00;
        sie_view[sie_pkg::SIE_DEFER] = r.defer;
        sie_view[sie_pkg::SIE_CTRL_FIFO_ERROR] = fl_q[sie_pkg::FL_CTRL_FIFO_ERROR];
        sie_view[sie_pkg::SIE_OUT] = fl_q[sie_pkg::FL_OUT];
        sie_view[sie_pkg::SIE_IN] = r.in_tok;
        sie_view[sie_pkg::SIE_NAK] = r.nak;
        sie_view[sie_pkg::SIE_CRC] = fl_q[sie_pkg::FL_CRC];
        sie_view[sie_pkg::SIE_END_OF_TRANSFER] = r.end_of_transfer_ok;
        sie_view[sie_pkg::SIE_NAK_IRQ_MASK] = r.nak_irq_mask;
        fc_view = 8'h00;
        fc_view[sie_pkg::FC_REQ] = r.cmd.req;
        fc_view[sie_pkg::FC_TX] = r.cmd.tx;
        fc_view[sie_pkg::FC_CLR] = r.cmd.clr;
        fc_view[sie_pkg::FC_SEL_HI:sie_pkg::FC_SEL_LO] = r.cmd.sel;
        fc_view[sie_pkg::FC_SETUP] = fl_q[sie_pkg::FL_SETUP];
        fc_view[sie_pkg::FC_READY] = SIE_EV.fifo_ready;
        fc_view[sie_pkg::FC_ZLEN] = fl_q[sie_pkg::FL_ZLEN];
    end

    // =====================================================
    // next state
    always_comb begin
        n = r;
        n.rdata = 8'h00;
        if (BUS_RD) begin
            unique case (BUS_ADDR)
                sie_pkg::OFS_DEV_ADDR: begin
                    n.rdata = r.addr_reg;
                end
                sie_pkg::OFS_SIE_STATUS: begin
                    n.rdata = sie_view;
                end
                sie_pkg::OFS_FIFO_CMD: begin
                    n.rdata = fc_view;
                end
                sie_pkg::OFS_IRQ_STATUS: begin
                    n.rdata = {2'h0, irq_stat};
                end
                sie_pkg::OFS_IRQ_MASK: begin
                    n.rdata = {2'h0, irq_mask};
                end
                default: begin
                    n.rdata = 8'h00;
                end
            endcase
        end
        n.end_of_transfer_ok = SIE_EV.end_of_transfer_ok;
        if (SIE_EV.token_start) begin
            n.in_tok = SIE_EV.token_is_in;
            n.nak = 1'b0;
        end
        if (SIE_EV.nak_sent) begin
            n.nak = 1'b1;
        end
        if (r.defer && SIE_EV.in_done) begin
            n.dev_addr = r.addr_reg[7:1];
            n.defer = 1'b0;
        end
        if (wr_dev) begin
            n.addr_reg = BUS_WDATA;
            if (!r.defer) begin
                n.dev_addr = BUS_WDATA[7:1];
            end
        end
        if (wr_sie) begin
            n.defer = BUS_WDATA[sie_pkg::SIE_DEFER];
            n.nak_irq_mask = BUS_WDATA[sie_pkg::SIE_NAK_IRQ_MASK];
        end
        if (wr_fc) begin
            n.cmd.req = BUS_WDATA[sie_pkg::FC_REQ];
            n.cmd.tx = BUS_WDATA[sie_pkg::FC_TX];
            n.cmd.clr = BUS_WDATA[sie_pkg::FC_CLR];
            n.cmd.sel = BUS_WDATA[sie_pkg::FC_SEL_HI:sie_pkg::FC_SEL_LO];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            r <= '0;
            r.addr_reg <= sie_pkg::DEV_ADDR_RST;
            r.dev_addr <= sie_pkg::DEV_ADDR_RST[7:1];
            r.nak_irq_mask <= sie_pkg::NAK_IRQ_MASK_RST;
            r.cmd <= sie_pkg::FIFO_CMD_RST[4:0];
        end else begin
            r <= n;
        end
    end

    // =====================================================
    // outputs
    assign BUS_RDATA = r.rdata;
    assign DEV_ADDR = r.dev_addr;
    assign REMOTE_WAKEUP = r.addr_reg[0];
    assign FIFO_CMD = r.cmd;

    // =====================================================
    // assertions
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    property p_defer_load;
        r.defer && SIE_EV.in_done |=> DEV_ADDR == $past(r.addr_reg[7:1]);
    endproperty
    a_defer_load: assert property (p_defer_load) else $error("deferred address not loaded");

    property p_defer_clear;
        r.defer && SIE_EV.in_done && !wr_sie |=> !r.defer;
    endproperty
    a_defer_clear: assert property (p_defer_clear) else $error("deferred bit not cleared");

    property p_defer_hold;
        r.defer && !SIE_EV.in_done |=> $stable(DEV_ADDR);
    endproperty
    a_defer_hold: assert property (p_defer_hold) else $error("address changed early");

    property p_now_load;
        wr_dev && !r.defer |=> DEV_ADDR == $past(BUS_WDATA[7:1]);
    endproperty
    a_now_load: assert property (p_now_load) else $error("immediate address not taken");

    property p_ctrl_fifo_error;
        SIE_EV.ctrl_fifo_error |=> fl_q[sie_pkg::FL_CTRL_FIFO_ERROR] ##1 (fl_q[sie_pkg::FL_CTRL_FIFO_ERROR]
            || $past(wr_sie));
    endproperty
    a_ctrl_fifo_error: assert property (p_ctrl_fifo_error) else $error("fifo0 error flag lost");

    property p_out_set;
        SIE_EV.out_rx ##1 !fl_clr[sie_pkg::FL_OUT] ##1 (BUS_RD && BUS_ADDR == sie_pkg::OFS_SIE_STATUS)
            |=> BUS_RDATA[sie_pkg::SIE_OUT];
    endproperty
    a_out_set: assert property (p_out_set) else $error("out flag not readable");

    property p_out_setup;
        SIE_EV.setup_rx && !SIE_EV.out_rx |=> !fl_q[sie_pkg::FL_OUT];
    endproperty
    a_out_setup: assert property (p_out_setup) else $error("out flag kept after setup");

    property p_in_tok;
        SIE_EV.token_start |=> r.in_tok == $past(SIE_EV.token_is_in);
    endproperty
    a_in_tok: assert property (p_in_tok) else $error("in token bit wrong");

    property p_nak;
        SIE_EV.nak_sent |=> r.nak;
    endproperty
    a_nak: assert property (p_nak) else $error("nak bit not set");

    property p_crc;
        SIE_EV.crc_err |=> fl_q[sie_pkg::FL_CRC];
    endproperty
    a_crc: assert property (p_crc) else $error("crc flag not set");

    property p_end_of_transfer_read;
        BUS_RD && BUS_ADDR == sie_pkg::OFS_SIE_STATUS
            |=> BUS_RDATA[sie_pkg::SIE_END_OF_TRANSFER] == $past(r.end_of_transfer_ok);
    endproperty
    a_end_of_transfer_read: assert property (p_end_of_transfer_read) else $error("end of transfer bit wrong");

    property p_nak_mask;
        r.nak_irq_mask && SIE_EV.nak_sent |=> !irq_stat[3] || $past(irq_stat[3]);
    endproperty
    a_nak_mask: assert property (p_nak_mask) else $error("masked nak raised");

    property p_fc_write;
        wr_fc |=> FIFO_CMD.sel == $past(BUS_WDATA[4:3]) && FIFO_CMD.req == $past(BUS_WDATA[0])
            && FIFO_CMD.tx == $past(BUS_WDATA[1]) && FIFO_CMD.clr == $past(BUS_WDATA[2]);
    endproperty
    a_fc_write: assert property (p_fc_write) else $error("fifo command not stored");

    property p_zlen_clr;
        (SIE_EV.fifo_data_rd || SIE_EV.setup_rx) && !SIE_EV.zero_len_rx |=> !fl_q[sie_pkg::FL_ZLEN];
    endproperty
    a_zlen_clr: assert property (p_zlen_clr) else $error("zero length not cleared");

    property p_w1_keep;
        wr_sie && BUS_WDATA[sie_pkg::SIE_CRC] |=> fl_q[sie_pkg::FL_CRC] == $past(fl_q[sie_pkg::FL_CRC])
            || $past(SIE_EV.crc_err);
    endproperty
    a_w1_keep: assert property (p_w1_keep) else $error("write one changed flag");

    property p_irq_level;
        ##1 IRQ == |(irq_stat & irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    property p_rdata_idle;
        !BUS_RD |=> BUS_RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    property p_nak_clear;
        SIE_EV.token_start && !SIE_EV.nak_sent |=> !r.nak;
    endproperty
    a_nak_clear: assert property (p_nak_clear) else $error("nak bit kept over new token");

    property p_in_hold;
        !SIE_EV.token_start |=> $stable(r.in_tok);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("in token bit changed without token");

    property p_zlen_set;
        SIE_EV.zero_len_rx |=> fl_q[sie_pkg::FL_ZLEN];
    endproperty
    a_zlen_set: assert property (p_zlen_set) else $error("zero length flag not set");

    property p_out_w0;
        wr_sie && !BUS_WDATA[sie_pkg::SIE_OUT] && !SIE_EV.out_rx |=> !fl_q[sie_pkg::FL_OUT];
    endproperty
    a_out_w0: assert property (p_out_w0) else $error("write zero kept out flag");

    property p_wakeup;
        wr_dev |=> REMOTE_WAKEUP == $past(BUS_WDATA[0]);
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wakeup bit not stored");

    property p_mask_write;
        wr_sie |=> r.nak_irq_mask == $past(BUS_WDATA[sie_pkg::SIE_NAK_IRQ_MASK]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("nak mask bit not stored");

    property p_sel_read;
        BUS_RD && BUS_ADDR == sie_pkg::OFS_FIFO_CMD
            |=> BUS_RDATA[sie_pkg::FC_SEL_HI:sie_pkg::FC_SEL_LO] == $past(FIFO_CMD.sel);
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("fifo select read back wrong");

    c_defer: cover property (r.defer && SIE_EV.in_done ##1 !r.defer);
    c_zlen_setup: cover property (fl_q[sie_pkg::FL_ZLEN] ##1 SIE_EV.setup_rx);
    c_irq: cover property (IRQ ##1 wr_ist ##1 !IRQ);
    c_fc_req: cover property (wr_fc && BUS_WDATA[0] ##[1:20] wr_fc && !BUS_WDATA[0]);

endmodule

// ==== rtl/sticky_flag.sv ====
module sticky_flag (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic set,
    input wire logic clr,
    // state
    output logic q
);

    sie_pkg::flag_state_t r, n;

    // =====================================================
    // set wins over a clear in the same cycle
    always_comb begin
        n = r;
        if (clr) begin
            n.q = 1'b0;
        end
        if (set) begin
            n.q = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.q;

endmodule

// ==== sim/usb_host_model.sv ====
module usb_host_model (
    // clock
    input wire logic clk,
    // engine events seen by the register block
    output sie_pkg::sie_ev_t ev
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // levels kept between pulses
    function automatic sie_pkg::sie_ev_t keep(input sie_pkg::sie_ev_t v);
        sie_pkg::sie_ev_t k;
        k = '0;
        k.end_of_transfer_ok = v.end_of_transfer_ok;
        k.fifo_ready = v.fifo_ready;
        return k;
    endfunction

    initial begin
        ev = '0;
        ev.end_of_transfer_ok = 1'b1;
    end

    // ==========================================
    // one-cycle event pulse, token direction inverted and held after the pulse
    task automatic pulse(input sie_pkg::sie_ev_t p);
        sie_pkg::sie_ev_t n;
        @(posedge clk);
        ev <= p | keep(ev);
        @(posedge clk);
        n = keep(ev);
        n.token_is_in = ~p.token_is_in;
        ev <= n;
    endtask

    task automatic set_ready(input logic r);
        @(posedge clk);
        ev.fifo_ready <= r;
    endtask
endmodule

// ==== sim/usb_sie_status_fifo_control_test.sv ====
module usb_sie_status_fifo_control_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk;
    logic rst;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_rdata;
    logic [6:0] dev_addr;
    logic remote_wakeup;
    logic irq;
    sie_pkg::sie_ev_t sie_ev;
    sie_pkg::fifo_cmd_t fifo_cmd;
    sie_pkg::sie_ev_t e;
    int mismatches = 0;
    int cmp_count = 0;

    sie_regs dut_u (
        .MCLK(mclk), .RST(rst), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr),
        .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .SIE_EV(sie_ev), .DEV_ADDR(dev_addr),
        .REMOTE_WAKEUP(remote_wakeup), .FIFO_CMD(fifo_cmd), .IRQ(irq)
    );

    usb_host_model host_u (.clk(mclk), .ev(sie_ev));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ==========================================
    // bus tasks and comparison
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        chk(name, exp, bus_rdata);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset;
        rd("status", 8'h45, 8'h40);
        rd("fifo", 8'h46, 8'h00);
        chk("addr", 8'h00, {1'b0, dev_addr});
        rd("unmapped", 8'h50, 8'h00);
    endtask

    task automatic t_address;
        wr(8'h42, 8'hA5);
        settle(1);
        chk("addr now", 8'h52, {1'b0, dev_addr});
        chk("wakeup", 8'h01, {7'h00, remote_wakeup});
        wr(8'h45, 8'h01);
        wr(8'h42, 8'h14);
        settle(3);
        chk("addr held", 8'h52, {1'b0, dev_addr});
        e = '0;
        e.in_done = 1'b1;
        host_u.pulse(e);
        settle(1);
        chk("addr late", 8'h0A, {1'b0, dev_addr});
        rd("defer off", 8'h45, 8'h40);
    endtask

    task automatic t_flags;
        e = '0;
        e.ctrl_fifo_error = 1'b1;
        e.out_rx = 1'b1;
        e.crc_err = 1'b1;
        host_u.pulse(e);
        rd("flags set", 8'h45, 8'h66);
        rd("out set", 8'h45, 8'h66);
        wr(8'h45, 8'h24);
        rd("f0 cleared", 8'h45, 8'h64);
        e = '0;
        e.setup_rx = 1'b1;
        host_u.pulse(e);
        rd("out by setup", 8'h45, 8'h60);
        wr(8'h45, 8'h00);
        rd("flags clear", 8'h45, 8'h40);
    endtask

    task automatic t_token;
        e = '0;
        e.token_start = 1'b1;
        e.token_is_in = 1'b1;
        host_u.pulse(e);
        e = '0;
        e.nak_sent = 1'b1;
        host_u.pulse(e);
        rd("in nak", 8'h45, 8'h58);
        e = '0;
        e.token_start = 1'b1;
        host_u.pulse(e);
        rd("out token", 8'h45, 8'h40);
    endtask

    task automatic t_fifo;
        logic [7:0] d;
        host_u.set_ready(1'b1);
        for (int s = 0; s < 3; s++) begin
            d = {3'h0, 5'(s << 3)} | 8'h03 | ((s == 2) ? 8'h04 : 8'h00);
            wr(8'h46, d);
            settle(1);
            chk("cmd", {3'h0, d[0], d[1], d[2], d[4:3]}, {3'h0, fifo_cmd});
            rd("fifo reg", 8'h46, d | 8'h40);
        end
        wr(8'h46, 8'h00);
        host_u.set_ready(1'b0);
        settle(1);
        chk("req drop", 8'h00, {3'h0, fifo_cmd});
    endtask

    task automatic t_zero;
        e = '0;
        e.zero_len_rx = 1'b1;
        host_u.pulse(e);
        rd("zlen", 8'h46, 8'h80);
        e = '0;
        e.fifo_data_rd = 1'b1;
        host_u.pulse(e);
        rd("zlen read", 8'h46, 8'h00);
        e = '0;
        e.zero_len_rx = 1'b1;
        host_u.pulse(e);
        e = '0;
        e.setup_rx = 1'b1;
        host_u.pulse(e);
        rd("zlen setup", 8'h46, 8'h20);
        wr(8'h46, 8'h00);
    endtask

    task automatic t_irq;
        wr(8'h4C, 8'h3F);
        wr(8'h45, 8'h00);
        wr(8'h4D, 8'h08);
        e = '0;
        e.nak_sent = 1'b1;
        host_u.pulse(e);
        settle(2);
        chk("irq nak", 8'h01, {7'h00, irq});
        rd("irq stat", 8'h4C, 8'h08);
        wr(8'h4C, 8'h08);
        settle(2);
        chk("irq clear", 8'h00, {7'h00, irq});
        wr(8'h45, 8'h80);
        host_u.pulse(e);
        settle(2);
        chk("irq masked", 8'h00, {7'h00, irq});
        rd("irq stat m", 8'h4C, 8'h00);
        rd("mask bit", 8'h45, 8'hD0);
    endtask

    // ==========================================
    // verdict
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_address();
        t_flags();
        t_token();
        t_fifo();
        t_zero();
        t_irq();
        results();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        results();
    end
endmodule
